/* inc/insn_decode_defines.svh */
`ifndef INSN_DECODE_DEFINES_SVH
`define INSN_DECODE_DEFINES_SVH

// ====================================================================
// lengths and execution times
`define LEN_1        2'h1
`define LEN_2        2'h2
`define LEN_3        2'h3
`define CYC_SHORT    3'h2
`define CYC_LONG     3'h4
`define CNT_RESET    3'h0
// bit field that carries the working register number
`define REG_LSB      0
`define ABS_MARK     5'h01
`define ABS_CALL_M   5'h11

// ====================================================================
// logical group
`define OP_AND_REG   8'b0101_1???
`define OP_AND_DIR   8'h55
`define OP_AND_IND   8'b0101_011?
`define OP_AND_IMM   8'h54
`define OP_AND_DIRA  8'h52
`define OP_AND_DIRI  8'h53
`define OP_OR_REG    8'b0100_1???
`define OP_OR_DIR    8'h45
`define OP_OR_IND    8'b0100_011?
`define OP_OR_IMM    8'h44
`define OP_OR_DIRA   8'h42
`define OP_OR_DIRI   8'h43
`define OP_XOR_REG   8'b0110_1???
`define OP_XOR_DIR   8'h65
`define OP_XOR_IND   8'b0110_011?
`define OP_XOR_IMM   8'h64
`define OP_XOR_DIRA  8'h62
`define OP_XOR_DIRI  8'h63
`define OP_RL        8'h23
`define OP_RL_CARRY  8'h33
`define OP_RR        8'h03
`define OP_RR_CARRY  8'h13

// ====================================================================
// data transfer
`define OP_MOV_AREG  8'b1110_1???
`define OP_MOV_REGA  8'b1111_1???
`define OP_MOV_REGD  8'b1010_1???
`define OP_MOV_REGI  8'b0111_1???
`define OP_MOV_DREG  8'b1000_1???
`define OP_MOV_DD    8'h85
`define OP_PTR_LOAD  8'h90
`define OP_CRD_PTR   8'h93
`define OP_CRD_PC    8'h83
`define OP_XRD_PTR   8'he0
`define OP_XWR_PTR   8'hf0
`define OP_XRD_IND   8'b1110_001?
`define OP_XWR_IND   8'b1111_001?
`define OP_PUSH      8'hc0
`define OP_POP       8'hd0

// ====================================================================
// boolean
`define OP_AND_CB    8'h82
`define OP_AND_CNB   8'hb0
`define OP_OR_CB     8'h72
`define OP_OR_CNB    8'ha0
`define OP_MOV_BC    8'h92
`define OP_MOV_CB    8'ha2
`define OP_CLR_B     8'hc2
`define OP_SET_B     8'hd2
`define OP_CPL_B     8'hb2
`define OP_CLR_C     8'hc3
`define OP_SET_C     8'hd3
`define OP_CPL_C     8'hb3

// ====================================================================
// branching and misc
`define OP_ABS_JUMP  8'b???0_0001
`define OP_ABS_CALL  8'b???1_0001
`define OP_FAR_CALL  8'h12
`define OP_FAR_JUMP  8'h02
`define OP_RET       8'h22
`define OP_INT_RET   8'h32
`define OP_JB_CLR    8'h10
`define OP_JB        8'h20
`define OP_JNB       8'h30
`define OP_CMP_AI    8'hb4
`define OP_CMP_AD    8'hb5
`define OP_CMP_RI    8'b1011_1???
`define OP_CMP_II    8'b1011_011?
`define OP_DEC_REG   8'b1101_1???
`define OP_DEC_DIR   8'hd5
`define OP_REL_JUMP  8'h80
`define OP_JC        8'h40
`define OP_JNC       8'h50
`define OP_JZ        8'h60
`define OP_JNZ       8'h70
`define OP_JMP_IND   8'h73
`define OP_NOP       8'h00

`endif

/* inc/insn_decode_pkg.sv */
package insn_decode_pkg;

  // ==================================================================
  // instruction groups
  typedef enum logic [4:0] {
    GRP_NONE, GRP_LOGIC_ACC, GRP_LOGIC_DIR, GRP_LOGIC_IMM_DIR, GRP_ROTATE,
    GRP_MOVE, GRP_CODE_READ, GRP_XDATA, GRP_PTR_LOAD, GRP_STACK, GRP_BOOL,
    GRP_ABS_JUMP, GRP_ABS_CALL, GRP_LONG_JUMP, GRP_LONG_CALL, GRP_RETURN,
    GRP_BIT_BRANCH, GRP_COMPARE, GRP_DEC_BRANCH, GRP_REL_BRANCH, GRP_IND_JUMP,
    GRP_NOP
  } group_t;

  typedef enum logic [1:0] {LOP_NONE, LOP_AND, LOP_OR, LOP_XOR} logic_op_t;

  // ==================================================================
  // sequencer states, one-hot
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_EXEC = 2'b10} state_t;

  // ==================================================================
  // instruction fetched bytes
  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  operand1;
    logic [7:0]  operand2;
    logic [15:0] addr;
  } fetch_t;

  // ==================================================================
  // decode result
  typedef struct packed {
    logic        known;
    group_t      group;
    logic_op_t   logic_op;
    logic [1:0]  length;
    logic [2:0]  cycles;
    logic        has_reg;
    logic [2:0]  reg_num;
    logic [2:0]  sub_op;
    logic        has_target;
    logic [15:0] target;
  } decode_t;

endpackage

/* hw/insn_decode.sv */
`timescale 1ns/1ps
`include "insn_decode_defines.svh"

module insn_decode
  import insn_decode_pkg::*;
(
  // clock and reset
  input  wire logic    clk,
  input  wire logic    rst,
  // fetched instruction
  input  wire logic    fetch_valid,
  input  wire fetch_t  fetch,
  // decode result and sequencing
  output logic         ready_q,
  output logic         done_q,
  output decode_t      dec_q
);

  // ==================================================================
  // table entry builder
  function automatic decode_t mk(group_t g, logic_op_t l, logic [1:0] len,
                                 logic [2:0] cyc, logic r, logic [2:0] s);
    decode_t e;
    e            = '0;
    e.known      = 1'b1;
    e.group      = g;
    e.logic_op   = l;
    e.length     = len;
    e.cycles     = cyc;
    e.has_reg    = r;
    e.sub_op     = s;
    return e;
  endfunction

  state_t      state_q, state_d;
  logic [2:0]  cnt_q, cnt_d;
  logic        ready_d, done_d;
  decode_t     dec_d, row;
  logic        accept;
  logic [15:0] next_pc;
  logic [7:0]  rel_off;

  assign accept = ready_q && fetch_valid;

  // ==================================================================
  // opcode table
  always_comb begin
    row = '0;
    row.cycles = `CYC_SHORT;
    unique casez (fetch.opcode)
      `OP_AND_REG:  row = mk(GRP_LOGIC_ACC, LOP_AND, `LEN_1, `CYC_SHORT, 1'b1, 3'h0);
      `OP_AND_DIR:  row = mk(GRP_LOGIC_ACC, LOP_AND, `LEN_2, `CYC_SHORT, 1'b0, 3'h1);
      `OP_AND_IND:  row = mk(GRP_LOGIC_ACC, LOP_AND, `LEN_1, `CYC_SHORT, 1'b0, 3'h2);
      `OP_AND_IMM:  row = mk(GRP_LOGIC_ACC, LOP_AND, `LEN_2, `CYC_SHORT, 1'b0, 3'h3);
      `OP_AND_DIRA: row = mk(GRP_LOGIC_DIR, LOP_AND, `LEN_2, `CYC_SHORT, 1'b0, 3'h0);
      `OP_OR_REG:   row = mk(GRP_LOGIC_ACC, LOP_OR, `LEN_1, `CYC_SHORT, 1'b1, 3'h0);
      `OP_OR_DIR:   row = mk(GRP_LOGIC_ACC, LOP_OR, `LEN_2, `CYC_SHORT, 1'b0, 3'h1);
      `OP_OR_IND:   row = mk(GRP_LOGIC_ACC, LOP_OR, `LEN_1, `CYC_SHORT, 1'b0, 3'h2);
      `OP_OR_IMM:   row = mk(GRP_LOGIC_ACC, LOP_OR, `LEN_2, `CYC_SHORT, 1'b0, 3'h3);
      `OP_OR_DIRA:  row = mk(GRP_LOGIC_DIR, LOP_OR, `LEN_2, `CYC_SHORT, 1'b0, 3'h0);
      `OP_XOR_REG:  row = mk(GRP_LOGIC_ACC, LOP_XOR, `LEN_1, `CYC_SHORT, 1'b1, 3'h0);
      `OP_XOR_DIR:  row = mk(GRP_LOGIC_ACC, LOP_XOR, `LEN_2, `CYC_SHORT, 1'b0, 3'h1);
      `OP_XOR_IND:  row = mk(GRP_LOGIC_ACC, LOP_XOR, `LEN_1, `CYC_SHORT, 1'b0, 3'h2);
      `OP_XOR_IMM:  row = mk(GRP_LOGIC_ACC, LOP_XOR, `LEN_2, `CYC_SHORT, 1'b0, 3'h3);
      `OP_XOR_DIRA: row = mk(GRP_LOGIC_DIR, LOP_XOR, `LEN_2, `CYC_SHORT, 1'b0, 3'h0);
      `OP_AND_DIRI: row = mk(GRP_LOGIC_IMM_DIR, LOP_AND, `LEN_3, `CYC_LONG, 1'b0, 3'h0);
      `OP_OR_DIRI:  row = mk(GRP_LOGIC_IMM_DIR, LOP_OR, `LEN_3, `CYC_LONG, 1'b0, 3'h0);
      `OP_XOR_DIRI: row = mk(GRP_LOGIC_IMM_DIR, LOP_XOR, `LEN_3, `CYC_LONG, 1'b0, 3'h0);
      // rotations, sub_op bit0 left, bit1 via carry
      `OP_RL:       row = mk(GRP_ROTATE, LOP_NONE, `LEN_1, `CYC_SHORT, 1'b0, 3'h1);
      `OP_RL_CARRY: row = mk(GRP_ROTATE, LOP_NONE, `LEN_1, `CYC_SHORT, 1'b0, 3'h3);
      `OP_RR:       row = mk(GRP_ROTATE, LOP_NONE, `LEN_1, `CYC_SHORT, 1'b0, 3'h0);
      `OP_RR_CARRY: row = mk(GRP_ROTATE, LOP_NONE, `LEN_1, `CYC_SHORT, 1'b0, 3'h2);
      // register moves
      `OP_MOV_AREG: row = mk(GRP_MOVE, LOP_NONE, `LEN_1, `CYC_SHORT, 1'b1, 3'h0);
      `OP_MOV_REGA: row = mk(GRP_MOVE, LOP_NONE, `LEN_1, `CYC_SHORT, 1'b1, 3'h1);
      `OP_MOV_DREG: row = mk(GRP_MOVE, LOP_NONE, `LEN_2, `CYC_LONG, 1'b1, 3'h4);
      `OP_MOV_REGD: row = mk(GRP_MOVE, LOP_NONE, `LEN_2, `CYC_LONG, 1'b1, 3'h2);
      `OP_MOV_REGI: row = mk(GRP_MOVE, LOP_NONE, `LEN_2, `CYC_SHORT, 1'b1, 3'h3);
      `OP_MOV_DD:   row = mk(GRP_MOVE, LOP_NONE, `LEN_3, `CYC_LONG, 1'b0, 3'h5);
      `OP_PTR_LOAD: row = mk(GRP_PTR_LOAD, LOP_NONE, `LEN_3, `CYC_LONG, 1'b0, 3'h0);
      // code reads, sub_op 1 means data pointer base
      `OP_CRD_PTR:  row = mk(GRP_CODE_READ, LOP_NONE, `LEN_1, `CYC_LONG, 1'b0, 3'h1);
      `OP_CRD_PC:   row = mk(GRP_CODE_READ, LOP_NONE, `LEN_1, `CYC_LONG, 1'b0, 3'h0);
      // external data, bit0 write, bit1 16-bit address
      `OP_XRD_PTR:  row = mk(GRP_XDATA, LOP_NONE, `LEN_1, `CYC_LONG, 1'b0, 3'h2);
      `OP_XWR_PTR:  row = mk(GRP_XDATA, LOP_NONE, `LEN_1, `CYC_LONG, 1'b0, 3'h3);
      `OP_XRD_IND:  row = mk(GRP_XDATA, LOP_NONE, `LEN_1, `CYC_LONG, 1'b0, 3'h0);
      `OP_XWR_IND:  row = mk(GRP_XDATA, LOP_NONE, `LEN_1, `CYC_LONG, 1'b0, 3'h1);
      `OP_PUSH:     row = mk(GRP_STACK, LOP_NONE, `LEN_2, `CYC_LONG, 1'b0, 3'h0);
      `OP_POP:      row = mk(GRP_STACK, LOP_NONE, `LEN_2, `CYC_LONG, 1'b0, 3'h1);
      // bit into carry, sub_op 1 means inverted bit
      `OP_AND_CB:   row = mk(GRP_BOOL, LOP_AND, `LEN_2, `CYC_LONG, 1'b0, 3'h0);
      `OP_AND_CNB:  row = mk(GRP_BOOL, LOP_AND, `LEN_2, `CYC_LONG, 1'b0, 3'h1);
      `OP_OR_CB:    row = mk(GRP_BOOL, LOP_OR, `LEN_2, `CYC_LONG, 1'b0, 3'h0);
      `OP_OR_CNB:   row = mk(GRP_BOOL, LOP_OR, `LEN_2, `CYC_LONG, 1'b0, 3'h1);
      `OP_MOV_BC:   row = mk(GRP_BOOL, LOP_NONE, `LEN_2, `CYC_LONG, 1'b0, 3'h2);
      `OP_MOV_CB:   row = mk(GRP_BOOL, LOP_NONE, `LEN_2, `CYC_SHORT, 1'b0, 3'h3);
      // clear, set, invert of bit and carry
      `OP_CLR_B:    row = mk(GRP_BOOL, LOP_NONE, `LEN_2, `CYC_SHORT, 1'b0, 3'h4);
      `OP_SET_B:    row = mk(GRP_BOOL, LOP_NONE, `LEN_2, `CYC_SHORT, 1'b0, 3'h5);
      `OP_CPL_B:    row = mk(GRP_BOOL, LOP_NONE, `LEN_2, `CYC_SHORT, 1'b0, 3'h6);
      `OP_CLR_C:    row = mk(GRP_BOOL, LOP_NONE, `LEN_1, `CYC_SHORT, 1'b0, 3'h4);
      `OP_SET_C:    row = mk(GRP_BOOL, LOP_NONE, `LEN_1, `CYC_SHORT, 1'b0, 3'h5);
      `OP_CPL_C:    row = mk(GRP_BOOL, LOP_NONE, `LEN_1, `CYC_SHORT, 1'b0, 3'h6);
      `OP_ABS_JUMP: row = mk(GRP_ABS_JUMP, LOP_NONE, `LEN_2, `CYC_LONG, 1'b0, 3'h0);
      `OP_ABS_CALL: row = mk(GRP_ABS_CALL, LOP_NONE, `LEN_2, `CYC_LONG, 1'b0, 3'h0);
      `OP_FAR_CALL: row = mk(GRP_LONG_CALL, LOP_NONE, `LEN_3, `CYC_LONG, 1'b0, 3'h0);
      `OP_FAR_JUMP: row = mk(GRP_LONG_JUMP, LOP_NONE, `LEN_3, `CYC_LONG, 1'b0, 3'h0);
      // returns, sub_op 1 for interrupt return
      `OP_RET:      row = mk(GRP_RETURN, LOP_NONE, `LEN_1, `CYC_LONG, 1'b0, 3'h0);
      `OP_INT_RET:  row = mk(GRP_RETURN, LOP_NONE, `LEN_1, `CYC_LONG, 1'b0, 3'h1);
      // bit tests, bit0 branch on one, bit1 clear bit
      `OP_JB_CLR:   row = mk(GRP_BIT_BRANCH, LOP_NONE, `LEN_3, `CYC_LONG, 1'b0, 3'h3);
      `OP_JB:       row = mk(GRP_BIT_BRANCH, LOP_NONE, `LEN_3, `CYC_LONG, 1'b0, 3'h1);
      `OP_JNB:      row = mk(GRP_BIT_BRANCH, LOP_NONE, `LEN_3, `CYC_LONG, 1'b0, 3'h0);
      `OP_CMP_AI:   row = mk(GRP_COMPARE, LOP_NONE, `LEN_3, `CYC_LONG, 1'b0, 3'h0);
      `OP_CMP_AD:   row = mk(GRP_COMPARE, LOP_NONE, `LEN_3, `CYC_LONG, 1'b0, 3'h1);
      `OP_CMP_RI:   row = mk(GRP_COMPARE, LOP_NONE, `LEN_3, `CYC_LONG, 1'b1, 3'h2);
      `OP_CMP_II:   row = mk(GRP_COMPARE, LOP_NONE, `LEN_3, `CYC_LONG, 1'b0, 3'h3);
      `OP_DEC_REG:  row = mk(GRP_DEC_BRANCH, LOP_NONE, `LEN_2, `CYC_LONG, 1'b1, 3'h0);
      `OP_DEC_DIR:  row = mk(GRP_DEC_BRANCH, LOP_NONE, `LEN_3, `CYC_LONG, 1'b0, 3'h1);
      // relative branches, sub_op names the condition
      `OP_REL_JUMP: row = mk(GRP_REL_BRANCH, LOP_NONE, `LEN_2, `CYC_LONG, 1'b0, 3'h0);
      `OP_JC:       row = mk(GRP_REL_BRANCH, LOP_NONE, `LEN_2, `CYC_LONG, 1'b0, 3'h1);
      `OP_JNC:      row = mk(GRP_REL_BRANCH, LOP_NONE, `LEN_2, `CYC_LONG, 1'b0, 3'h2);
      `OP_JZ:       row = mk(GRP_REL_BRANCH, LOP_NONE, `LEN_2, `CYC_LONG, 1'b0, 3'h3);
      `OP_JNZ:      row = mk(GRP_REL_BRANCH, LOP_NONE, `LEN_2, `CYC_LONG, 1'b0, 3'h4);
      `OP_JMP_IND:  row = mk(GRP_IND_JUMP, LOP_NONE, `LEN_1, `CYC_LONG, 1'b0, 3'h0);
      `OP_NOP:      row = mk(GRP_NOP, LOP_NONE, `LEN_1, `CYC_SHORT, 1'b0, 3'h0);
      default:      row.length = `LEN_1; // unsupported here, treated as one byte
    endcase
  end

  // ==================================================================
  // register number and destination address
  always_comb begin
    dec_d   = row;
    next_pc = fetch.addr + {14'h0, row.length};
    rel_off = (row.length == `LEN_3) ? fetch.operand2 : fetch.operand1;
    dec_d.reg_num = row.has_reg ? fetch.opcode[`REG_LSB +: 3] : 3'h0;
    unique case (row.group)
      // high five bits of next pc, top opcode bits, then next byte
      GRP_ABS_JUMP, GRP_ABS_CALL: begin
        dec_d.has_target = 1'b1;
        dec_d.target     = {next_pc[15:11], fetch.opcode[7:5], fetch.operand1};
      end
      GRP_LONG_JUMP, GRP_LONG_CALL: begin
        dec_d.has_target = 1'b1;
        dec_d.target     = {fetch.operand1, fetch.operand2};
      end
      GRP_BIT_BRANCH, GRP_COMPARE, GRP_DEC_BRANCH, GRP_REL_BRANCH: begin
        dec_d.has_target = 1'b1;
        dec_d.target     = next_pc + {{8{rel_off[7]}}, rel_off};
      end
      default: begin
        dec_d.has_target = 1'b0;
        dec_d.target     = 16'h0000;
      end
    endcase
  end

  // ==================================================================
  // execution sequencer next state
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    ready_d = ready_q;
    done_d  = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (accept) begin
          state_d = ST_EXEC;
          cnt_d   = dec_d.cycles - 3'h1;
          ready_d = 1'b0;
        end
      end
      ST_EXEC: begin
        cnt_d = cnt_q - 3'h1;
        if (cnt_q == 3'h1) begin
          state_d = ST_IDLE;
          ready_d = 1'b1;
          done_d  = 1'b1;
        end
      end
    endcase
  end

  // sequencer and decode registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q   <= `CNT_RESET;
      ready_q <= 1'b1;
      done_q  <= 1'b0;
      dec_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      ready_q <= ready_d;
      done_q  <= done_d;
      if (accept) begin
        dec_q <= dec_d;
      end
    end
  end

  // ==================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence long_run_s;
    !ready_q [*3] ##1 (ready_q && done_q);
  endsequence

  sequence short_run_s;
    !ready_q ##1 (ready_q && done_q);
  endsequence

  reg_number_a: assert property (
    accept |=> (!dec_q.has_reg || dec_q.reg_num == $past(fetch.opcode[2:0])))
    else $error("register number not taken from low opcode bits");

  abs_target_a: assert property (
    accept && fetch.opcode[4:0] == `ABS_MARK |=> dec_q.group == GRP_ABS_JUMP
      && dec_q.target[10:8] == $past(fetch.opcode[7:5]) && dec_q.length == `LEN_2)
    else $error("absolute jump decode wrong");

  abs_call_time_a: assert property (
    accept && fetch.opcode[4:0] == `ABS_CALL_M |=> long_run_s)
    else $error("absolute call not four cycles");

  dir_imm_a: assert property (
    accept && fetch.opcode inside {`OP_AND_DIRI, `OP_OR_DIRI, `OP_XOR_DIRI}
      |=> dec_q.length == `LEN_3 ##0 long_run_s)
    else $error("immediate into direct byte not 3 bytes and 4 cycles");

  acc_and_a: assert property (
    accept && fetch.opcode == `OP_AND_IMM |=> dec_q.logic_op == LOP_AND ##0 short_run_s)
    else $error("AND immediate not two cycles");

  rotate_time_a: assert property (
    accept && fetch.opcode == `OP_RL_CARRY |=> dec_q.length == `LEN_1 ##0 short_run_s)
    else $error("rotation timing wrong");

  long_target_a: assert property (
    accept && fetch.opcode == `OP_FAR_CALL
      |=> dec_q.target == {$past(fetch.operand1), $past(fetch.operand2)})
    else $error("long call destination wrong");

  bit_clear_a: assert property (
    accept && fetch.opcode == `OP_JB_CLR |=> dec_q.sub_op == 3'h3 && dec_q.length == `LEN_3)
    else $error("clearing bit branch decode wrong");

  rel_target_a: assert property (
    accept && fetch.opcode == `OP_REL_JUMP |=> dec_q.target == $past(fetch.addr) + 16'h0002
      + {{8{$past(fetch.operand1[7])}}, $past(fetch.operand1)})
    else $error("relative target wrong");

endmodule

/* test/code_mem.sv */
`timescale 1ns/1ps
// ============================================================
// program memory model
module code_mem
  import insn_decode_pkg::*;
(
  // clock
  input  wire logic        clk,
  // loading port
  input  wire logic        wr_en,
  input  wire logic [7:0]  wr_addr,
  input  wire logic [7:0]  wr_data,
  // fetch side
  input  wire logic [15:0] pc,
  output fetch_t           fetch
);
  logic [7:0] mem_q [256];
  logic [7:0] base;

  // byte store, loaded one byte per clock
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // three bytes from pc upward; the low address byte wraps
  assign base  = pc[7:0];
  assign fetch = '{opcode: mem_q[base], operand1: mem_q[base + 8'h01],
                   operand2: mem_q[base + 8'h02], addr: pc};
endmodule

/* test/tb_top.sv */
`timescale 1ns/1ps
// ============================================================
// decoder regression
module tb_top
  import insn_decode_pkg::*;
;

  logic        clk;
  logic        rst;
  logic        fetch_valid;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [15:0] pc;
  fetch_t      fetch;
  logic        ready_q;
  logic        done_q;
  decode_t     dec_q;
  int          n_fail;
  int          comparisons;

  // opcode, known, length, cycles
  logic [19:0] cases [$] = '{
    20'h58112, 20'h5f112, 20'h55122, 20'h56112, 20'h57112, 20'h54122, 20'h52122, 20'h53134,
    20'h48112, 20'h4f112, 20'h45122, 20'h46112, 20'h44122, 20'h42122, 20'h43134, 20'h68112,
    20'h6f112, 20'h65122, 20'h67112, 20'h64122, 20'h62122, 20'h63134, 20'h23112, 20'h03112,
    20'h33112, 20'h13112, 20'h93114, 20'h83114, 20'he0114, 20'hf0114, 20'he2114, 20'he3114,
    20'hf2114, 20'hf3114, 20'h90134, 20'h85134, 20'ha8124, 20'haf124, 20'h78122, 20'h7f122,
    20'hc0124, 20'hd0124, 20'h82124, 20'h72124, 20'ha0124, 20'hb0124, 20'h92124, 20'ha2122,
    20'hc2122, 20'hd2122, 20'hb2122, 20'hc3112, 20'hd3112, 20'hb3112, 20'h12134, 20'h02134,
    20'h22114, 20'h32114, 20'h10134, 20'h20134, 20'h30134, 20'hb4134, 20'hb5134, 20'hb6134,
    20'hb7134, 20'hb8134, 20'hbf134, 20'hd8124, 20'hdf124, 20'hd5134, 20'h80124, 20'h40124,
    20'h50124, 20'h60124, 20'h70124, 20'h01124, 20'he1124, 20'h11124, 20'hf1124, 20'h28012,
    20'he8112, 20'hf8112, 20'h8f124, 20'h73114, 20'h00112, 20'h66112
  };

  insn_decode DUT (
    .clk         (clk),
    .rst         (rst),
    .fetch_valid (fetch_valid),
    .fetch       (fetch),
    .ready_q     (ready_q),
    .done_q      (done_q),
    .dec_q       (dec_q)
  );

  code_mem prog_mem (
    .clk     (clk),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .pc      (pc),
    .fetch   (fetch)
  );

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ============================================================
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic timeout(input string what);
    n_fail++;
    $display("[FAIL] %0t no answer: %s", $time, what);
    finish_test();
  endtask

  // writes three bytes at a and points the fetch there
  task automatic load(input logic [15:0] a, input logic [7:0] b0, b1, b2);
    logic [7:0] bytes [3];
    bytes = '{b0, b1, b2};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      wr_en   <= 1'b1;
      wr_addr <= a[7:0] + 8'(i);
      wr_data <= bytes[i];
    end
    @(posedge clk);
    wr_en <= 1'b0;
    pc    <= a;
  endtask

  // raises the request and returns at the taking edge
  task automatic take();
    logic r;
    @(posedge clk);
    fetch_valid <= 1'b1;
    for (int k = 0; k < 20; k++) begin
      @(negedge clk);
      r = ready_q;
      @(posedge clk);
      if (r === 1'b1) begin
        return;
      end
    end
    timeout("take");
  endtask

  // m + 1 is the cycle count seen up to the done pulse
  task automatic wait_done(output int m);
    for (m = 0; m < 12; m++) begin
      @(negedge clk);
      if (m == 0) begin
        check(16'(ready_q), 16'h0, "busy after take");
      end
      if (done_q === 1'b1) begin
        return;
      end
    end
    timeout("done");
  endtask

  // ============================================================
  // scenarios
  task automatic reset_test();
    @(negedge clk);
    check(16'({ready_q, done_q, dec_q === '0}), 16'h5, "state in reset");
    @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check(16'({ready_q, done_q, dec_q === '0}), 16'h5, "state after reset");
    $display("reset test done");
  endtask

  task automatic table_test();
    int m;
    logic_op_t lop;
    foreach (cases[i]) begin
      load(16'h0040, cases[i][19:12], 8'h11, 8'h22);
      take();
      fetch_valid <= 1'b0;
      wait_done(m);
      check(16'(m + 1), 16'(cases[i][3:0]), "cycles to done");
      check(16'(ready_q), 16'h1, "ready with done");
      check(16'(dec_q.known), 16'(cases[i][11:8]), "known");
      check(16'(dec_q.length), 16'(cases[i][7:4]), "length");
      check(16'(dec_q.cycles), 16'(cases[i][3:0]), "cycles");
      if (cases[i][15] && cases[i][8]) begin
        check(16'({dec_q.has_reg, dec_q.reg_num}), 16'({1'b1, cases[i][14:12]}), "reg");
      end
      if (cases[i][19:16] inside {4'h4, 4'h5, 4'h6} && cases[i][15:12] != 4'h0) begin
        lop = (cases[i][19:16] == 4'h5) ? LOP_AND : (cases[i][19:16] == 4'h4) ? LOP_OR : LOP_XOR;
        check(16'(dec_q.logic_op), 16'(lop), "logic operator");
      end
      @(negedge clk);
      check(16'(done_q), 16'h0, "done pulse width");
    end
    $display("opcode table test done");
  endtask

  task automatic target_case(input logic [15:0] a, input logic [7:0] op, o1, o2,
                             input logic [15:0] exp);
    int m;
    load(a, op, o1, o2);
    take();
    fetch_valid <= 1'b0;
    wait_done(m);
    check(16'(dec_q.has_target), 16'h1, "has target");
    check(dec_q.target, exp, "target");
    $display("target test %h done", op);
  endtask

  // request held high while busy, then taken back to back
  task automatic busy_test();
    int m;
    load(16'h0090, 8'h00, 8'h00, 8'h00);
    load(16'h0080, 8'h85, 8'h30, 8'h31);
    take();
    pc <= 16'h0090;
    for (int k = 0; k < 3; k++) begin
      @(negedge clk);
      check(16'({ready_q, dec_q.group}), 16'({1'b0, GRP_MOVE}), "held while busy");
    end
    @(negedge clk);
    check(16'({ready_q, done_q}), 16'h3, "copy finished");
    @(posedge clk);
    fetch_valid <= 1'b0;
    wait_done(m);
    check(16'(m + 1), 16'h2, "no-op cycles");
    check(16'(dec_q.group), 16'(GRP_NOP), "no-op taken");
    $display("busy test done");
  endtask

  // ============================================================
  // main sequence
  initial begin
    rst         = 1'b1;
    fetch_valid = 1'b0;
    wr_en       = 1'b0;
    wr_addr     = 8'h00;
    wr_data     = 8'h00;
    pc          = 16'h0000;
    n_fail      = 0;
    comparisons = 0;
    repeat (3) @(posedge clk);
    reset_test();
    table_test();
    target_case(16'h0040, 8'h02, 8'h12, 8'h34, 16'h1234);
    target_case(16'h0050, 8'h12, 8'hab, 8'hcd, 16'habcd);
    target_case(16'h17fe, 8'he1, 8'h5a, 8'h00, 16'h1f5a);
    target_case(16'h07fe, 8'h31, 8'hc3, 8'h00, 16'h09c3);
    target_case(16'h0010, 8'h80, 8'hfe, 8'h00, 16'h0010);
    target_case(16'h0100, 8'hb4, 8'h33, 8'h05, 16'h0108);
    target_case(16'h0020, 8'hd8, 8'h80, 8'h00, 16'hffa2);
    target_case(16'h0030, 8'h10, 8'h20, 8'h10, 16'h0043);
    busy_test();
    finish_test();
  end
endmodule
